// File: include/cpu_sysreg_pkg.sv
// types shared by the system register logic
// assumes nothing beyond a SystemVerilog compiler
package cpu_sysreg_pkg;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_TRAP = 2'b01
  } trap_state_t;
endpackage

// File: include/cpu_sysreg_regs.svh
// system register numbers, field positions, reset values and widths
// assumes inclusion by bare name from design files
`ifndef CPU_SYSREG_REGS_SVH
`define CPU_SYSREG_REGS_SVH

`define SR_NMI_PC 5'h02
`define SR_NMI_PSW 5'h03
`define SR_CAUSE 5'h04
`define SR_PSW 5'h05
`define SR_TC_PC 5'h10
`define SR_TC_PSW 5'h11
`define SR_TRAP_PC 5'h12
`define SR_TRAP_PSW 5'h13
`define SR_TC_BASE 5'h14

`define PSW_NP 7
`define PSW_EP 6
`define PSW_ID 5
`define PSW_SAT 4
`define PSW_CY 3
`define PSW_OV 2
`define PSW_S 1
`define PSW_Z 0

`define PSW_W 8
`define PC_W 26
`define PSW_RESET 8'h20
`define RESET_ENTRY 26'h0000000
`define SAT_POS_MAX 32'h7fffffff
`define SAT_NEG_MAX 32'h80000000

`endif

// File: rtl/cpu_status_save_restore.sv
// status word, save registers and trap window for the core
// assumes pipeline pulses are one cycle and mutually exclusive
`timescale 1ns/1ns
`include "cpu_sysreg_regs.svh"
// Notes on behaviour
// [RULE_01] nmi copies pc and status word into nmi save pair
// [RULE_02] nmi saved pc is address of the following instruction
// [RULE_03] nmi saved pc top six and saved status top 24 bits read zero
// [RULE_04] interrupt return restores pc and status from nmi save pair
// [RULE_05] cause register captures each code; loads never change it
// [RULE_06] status word loads take effect right after the instruction
// [RULE_07] with interrupts disabled, no acknowledge during a status load
// [RULE_08] status word bits 31 to 8 are zero
// [RULE_09] bit 7 set on nmi acknowledge, blocks nesting
// [RULE_10] bit 6 set on exception; interrupts still acknowledged
// [RULE_11] bit 5 refuses maskable interrupts when one
// [RULE_12] bit 4 sticky on saturation, cleared only by load
// [RULE_13] bits 3..0 carry, overflow, negative, zero
// [RULE_14] saturation clamps to positive or negative limit with flags
// [RULE_15] sticky set only with overflow; else result unchanged
// [RULE_16] table call saves next pc and status word
// [RULE_17] table call save pair high bits held zero
// [RULE_18] trap saves next pc and status word into trap pair
// [RULE_19] trap pair accessible only between trap and trap return
// [RULE_20] trap return restores pc and status from trap pair
// [RULE_21] table base bit 0 and bits 31 to 26 are zero
// [RULE_22] after reset execution starts at the reset entry address
module cpu_status_save_restore #(
  parameter int CAUSE_W = 32
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [25:0] cur_pc,
  input wire logic [25:0] next_pc,
  input wire logic [15:0] cause_code,
  input wire logic nmi_req,
  input wire logic mask_req,
  input wire logic exception_take,
  input wire logic trap_take,
  input wire logic table_call_exec,
  input wire logic interrupt_return_exec,
  input wire logic trap_return_exec,
  input wire logic sysreg_load,
  input wire logic [4:0] sysreg_num,
  input wire logic [31:0] sysreg_wdata,
  input wire logic alu_flag_we,
  input wire logic [3:0] alu_flags,
  input wire logic sat_op,
  input wire logic [32:0] sat_sum,
  output logic [31:0] sysreg_rdata,
  output logic sysreg_err,
  output logic [31:0] sat_result_out,
  output logic nmi_ack,
  output logic mask_ack,
  output logic pc_load,
  output logic [25:0] pc_target,
  output logic [7:0] psw_out,
  output logic [25:0] table_base_out
);
  logic [7:0] psw_ff;
  logic [7:0] nxt_psw;
  logic [25:0] nmi_pc_ff;
  logic [7:0] nmi_psw_ff;
  logic [25:0] tc_pc_ff;
  logic [7:0] tc_psw_ff;
  logic [25:0] trap_pc_ff;
  logic [7:0] trap_psw_ff;
  logic [25:0] tc_base_ff;
  logic [CAUSE_W-1:0] cause_ff;
  cpu_sysreg_pkg::trap_state_t trap_st_ff;
  logic [31:0] rdata_ff;
  logic err_ff;
  logic [31:0] sat_res_ff;
  logic nmi_ack_ff;
  logic mask_ack_ff;
  logic pc_load_ff;
  logic [25:0] pc_target_ff;
  logic boot_ff;
  logic nmi_take;
  logic mask_take;
  logic [31:0] sat_result;
  logic sat_ov;
  logic sat_neg;
  logic sat_zero;
  logic trap_open;
  logic trap_num;
  logic load_ok;
  logic [31:0] rd_mux;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  irq_gate u_gate (
    .nmi_req(nmi_req),
    .mask_req(mask_req),
    .np_flag(psw_ff[`PSW_NP]),
    .id_flag(psw_ff[`PSW_ID]),
    .psw_load_busy(sysreg_load && sysreg_num == `SR_PSW &&
                   sysreg_wdata[`PSW_ID]),
    .nmi_take(nmi_take),
    .mask_take(mask_take)
  );

  sat_flag_calc u_sat (
    .sum_wide(sat_sum),
    .sat_result(sat_result),
    .sat_ov(sat_ov),
    .sat_neg(sat_neg),
    .sat_zero(sat_zero)
  );

  assign trap_open = (trap_st_ff == cpu_sysreg_pkg::ST_TRAP);
  assign trap_num = (sysreg_num == `SR_TRAP_PC) ||
                    (sysreg_num == `SR_TRAP_PSW);
  // trap pair writes outside the trap window are dropped and flagged
  assign load_ok = sysreg_load && (!trap_num || trap_open); // RULE_19

  // -----------------------------------------------------------------
  // status word
  // -----------------------------------------------------------------
  always_comb begin
    nxt_psw = psw_ff;
    if (alu_flag_we) begin
      nxt_psw[3:0] = alu_flags; // RULE_13
    end
    if (sat_op) begin
      nxt_psw[`PSW_OV] = sat_ov;
      nxt_psw[`PSW_S] = sat_neg;
      nxt_psw[`PSW_Z] = sat_zero;
      if (sat_ov) begin
        nxt_psw[`PSW_SAT] = 1'b1; // RULE_12 RULE_15
      end
    end
    if (load_ok && sysreg_num == `SR_PSW) begin
      nxt_psw = sysreg_wdata[7:0]; // RULE_06 RULE_08
    end
    if (interrupt_return_exec) begin
      nxt_psw = nmi_psw_ff; // RULE_04
    end
    if (trap_return_exec) begin
      nxt_psw = trap_psw_ff; // RULE_20
    end
    if (exception_take || trap_take) begin
      nxt_psw[`PSW_EP] = 1'b1; // RULE_10
      nxt_psw[`PSW_ID] = 1'b1;
    end
    if (nmi_take) begin
      nxt_psw[`PSW_NP] = 1'b1; // RULE_09
      nxt_psw[`PSW_ID] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      psw_ff <= `PSW_RESET;
    end else begin
      psw_ff <= nxt_psw;
    end
  end

  // -----------------------------------------------------------------
  // save registers
  // -----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      nmi_pc_ff <= 26'h0000000;
      nmi_psw_ff <= 8'h00;
    end else if (nmi_take) begin
      nmi_pc_ff <= next_pc; // RULE_01 RULE_02
      nmi_psw_ff <= psw_ff; // RULE_01
    end else if (load_ok && sysreg_num == `SR_NMI_PC) begin
      nmi_pc_ff <= sysreg_wdata[25:0]; // RULE_03
    end else if (load_ok && sysreg_num == `SR_NMI_PSW) begin
      nmi_psw_ff <= sysreg_wdata[7:0]; // RULE_03
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tc_pc_ff <= 26'h0000000;
      tc_psw_ff <= 8'h00;
    end else if (table_call_exec) begin
      tc_pc_ff <= next_pc; // RULE_16
      tc_psw_ff <= psw_ff; // RULE_16
    end else if (load_ok && sysreg_num == `SR_TC_PC) begin
      tc_pc_ff <= sysreg_wdata[25:0]; // RULE_17
    end else if (load_ok && sysreg_num == `SR_TC_PSW) begin
      tc_psw_ff <= sysreg_wdata[7:0]; // RULE_17
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      trap_pc_ff <= 26'h0000000;
      trap_psw_ff <= 8'h00;
    end else if (trap_take || exception_take) begin
      trap_pc_ff <= next_pc; // RULE_18
      trap_psw_ff <= psw_ff; // RULE_18
    end else if (load_ok && sysreg_num == `SR_TRAP_PC) begin
      trap_pc_ff <= sysreg_wdata[25:0]; // RULE_19
    end else if (load_ok && sysreg_num == `SR_TRAP_PSW) begin
      trap_psw_ff <= sysreg_wdata[7:0]; // RULE_19
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tc_base_ff <= 26'h0000000;
    end else if (load_ok && sysreg_num == `SR_TC_BASE) begin
      tc_base_ff <= {sysreg_wdata[25:1], 1'b0}; // RULE_21
    end
  end

  // cause only follows events; no load path exists on purpose
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cause_ff <= '0;
    end else if (nmi_take || mask_take || exception_take || trap_take) begin
      cause_ff <= CAUSE_W'(cause_code); // RULE_05
    end
  end

  // -----------------------------------------------------------------
  // trap window
  // -----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      trap_st_ff <= cpu_sysreg_pkg::ST_RUN;
    end else begin
      case (trap_st_ff)
        cpu_sysreg_pkg::ST_RUN: begin
          if (trap_take) begin
            trap_st_ff <= cpu_sysreg_pkg::ST_TRAP; // RULE_19
          end
        end
        default: begin
          if (trap_return_exec) begin
            trap_st_ff <= cpu_sysreg_pkg::ST_RUN; // RULE_19
          end
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // store path
  // -----------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h00000000;
    if (sysreg_num == `SR_NMI_PC) begin
      rd_mux = {6'h00, nmi_pc_ff}; // RULE_03
    end else if (sysreg_num == `SR_NMI_PSW) begin
      rd_mux = {24'h000000, nmi_psw_ff}; // RULE_03
    end else if (sysreg_num == `SR_CAUSE) begin
      rd_mux = 32'(cause_ff);
    end else if (sysreg_num == `SR_PSW) begin
      rd_mux = {24'h000000, psw_ff}; // RULE_08
    end else if (sysreg_num == `SR_TC_PC) begin
      rd_mux = {6'h00, tc_pc_ff}; // RULE_17
    end else if (sysreg_num == `SR_TC_PSW) begin
      rd_mux = {24'h000000, tc_psw_ff};
    end else if (sysreg_num == `SR_TRAP_PC && trap_open) begin
      rd_mux = {6'h00, trap_pc_ff}; // RULE_19
    end else if (sysreg_num == `SR_TRAP_PSW && trap_open) begin
      rd_mux = {24'h000000, trap_psw_ff}; // RULE_19
    end else if (sysreg_num == `SR_TC_BASE) begin
      rd_mux = {6'h00, tc_base_ff}; // RULE_21
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= 32'h00000000;
      err_ff <= 1'b0;
    end else begin
      rdata_ff <= rd_mux;
      err_ff <= sysreg_load && (!load_ok || sysreg_num == `SR_CAUSE);
    end
  end

  // -----------------------------------------------------------------
  // acknowledges, redirects and result
  // -----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      nmi_ack_ff <= 1'b0;
      mask_ack_ff <= 1'b0;
      sat_res_ff <= 32'h00000000;
    end else begin
      nmi_ack_ff <= nmi_take;
      mask_ack_ff <= mask_take && !nmi_take; // RULE_07 RULE_11
      sat_res_ff <= sat_result; // RULE_14
    end
  end

  // boot_ff makes the very first cycle after release a redirect
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      boot_ff <= 1'b1;
      pc_load_ff <= 1'b0;
      pc_target_ff <= `RESET_ENTRY;
    end else begin
      boot_ff <= 1'b0;
      pc_load_ff <= boot_ff || interrupt_return_exec || trap_return_exec;
      if (boot_ff) begin
        pc_target_ff <= `RESET_ENTRY; // RULE_22
      end else if (interrupt_return_exec) begin
        pc_target_ff <= {nmi_pc_ff[25:1], 1'b0}; // RULE_04
      end else if (trap_return_exec) begin
        pc_target_ff <= {trap_pc_ff[25:1], 1'b0}; // RULE_20
      end
    end
  end

  assign sysreg_rdata = rdata_ff;
  assign sysreg_err = err_ff;
  assign sat_result_out = sat_res_ff;
  assign nmi_ack = nmi_ack_ff;
  assign mask_ack = mask_ack_ff;
  assign pc_load = pc_load_ff;
  assign pc_target = pc_target_ff;
  assign psw_out = psw_ff;
  assign table_base_out = tc_base_ff;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  a_nmi_save_pc: assert property (@(posedge sys_clk) // RULE_02
    disable iff (!reset_n) nmi_take |=> nmi_pc_ff == $past(next_pc))
    else $error("nmi saved pc wrong");
  a_nmi_save_psw: assert property (@(posedge sys_clk) // RULE_01
    disable iff (!reset_n) nmi_take |=> nmi_psw_ff == $past(psw_ff) &&
    psw_ff[7]) else $error("nmi save or np flag wrong");
  a_nmi_blocks: assert property (@(posedge sys_clk) // RULE_09
    disable iff (!reset_n) psw_ff[7] |=> !nmi_ack_ff && !mask_ack_ff)
    else $error("ack while nmi in service");
  a_id_refuses: assert property (@(posedge sys_clk) // RULE_11
    disable iff (!reset_n) psw_ff[5] |=> !mask_ack_ff)
    else $error("maskable ack while disabled");
  a_sat_sticky: assert property (@(posedge sys_clk) // RULE_12
    disable iff (!reset_n) psw_ff[4] && !interrupt_return_exec &&
    !(sysreg_load && sysreg_num == `SR_PSW) && !trap_return_exec
    |=> psw_ff[4]) else $error("sticky bit lost");
  a_sat_clamp: assert property (@(posedge sys_clk) // RULE_14
    disable iff (!reset_n) sat_op && sat_ov && !sat_sum[32]
    |=> sat_res_ff == 32'h7fffffff && !psw_ff[1] && psw_ff[2])
    else $error("positive clamp wrong");
  a_cause_ro: assert property (@(posedge sys_clk) // RULE_05
    disable iff (!reset_n) sysreg_load && !exception_take &&
    !(nmi_take || mask_take || trap_take) |=> $stable(cause_ff))
    else $error("cause register changed by load");
  a_trap_window: assert property (@(posedge sys_clk) // RULE_19
    disable iff (!reset_n) !trap_open && !trap_take && !exception_take
    && sysreg_load && trap_num |=> $stable(trap_pc_ff) &&
    $stable(trap_psw_ff) && err_ff) else $error("trap pair touched");
  a_interrupt_return_restore: assert property (@(posedge sys_clk) // RULE_04
    disable iff (!reset_n) interrupt_return_exec && !nmi_take &&
    !exception_take && !trap_take |=> pc_load_ff &&
    psw_ff == $past(nmi_psw_ff)) else $error("interrupt return wrong");
  a_trap_restore: assert property (@(posedge sys_clk) // RULE_20
    disable iff (!reset_n) trap_return_exec && !interrupt_return_exec &&
    !nmi_take && !exception_take && !trap_take |=> pc_load_ff &&
    pc_target_ff == {$past(trap_pc_ff[25:1]), 1'b0})
    else $error("trap return restore wrong");
  a_base_even: assert property (@(posedge sys_clk) // RULE_21
    disable iff (!reset_n) !tc_base_ff[0]) else $error("table base odd");
  a_call_save: assert property (@(posedge sys_clk) // RULE_16
    disable iff (!reset_n) table_call_exec |=> tc_pc_ff == $past(next_pc)
    && tc_psw_ff == $past(psw_ff))
    else $error("table call save wrong");
endmodule

// File: rtl/irq_gate.sv
// interrupt acceptance gating from status flags
// assumes requests are levels held by the interrupt controller
`timescale 1ns/1ns
module irq_gate (
  input wire logic nmi_req,
  input wire logic mask_req,
  input wire logic np_flag,
  input wire logic id_flag,
  input wire logic psw_load_busy,
  output logic nmi_take,
  output logic mask_take
);
  // -----------------------------------------------------------------
  // gating
  // -----------------------------------------------------------------
  always_comb begin
    // the exception flag PSW_EP deliberately plays no part here
    nmi_take = nmi_req && !np_flag; // RULE_09 RULE_10
    // a status load that sets the disable bit refuses maskable acks while it runs
    mask_take = mask_req && !np_flag && !id_flag && // RULE_11
                !psw_load_busy; // RULE_07
  end
endmodule

// File: rtl/sat_flag_calc.sv
// saturation clamp and flag computation for saturating instructions
// assumes sum_wide is the exact 33-bit signed result of the operation
`timescale 1ns/1ns
`include "cpu_sysreg_regs.svh"
module sat_flag_calc (
  input wire logic [32:0] sum_wide,
  output logic [31:0] sat_result,
  output logic sat_ov,
  output logic sat_neg,
  output logic sat_zero
);
  logic pos_over;
  logic neg_over;
  // -----------------------------------------------------------------
  // clamp
  // -----------------------------------------------------------------
  always_comb begin
    pos_over = !sum_wide[32] && sum_wide[31];
    neg_over = sum_wide[32] && !sum_wide[31];
    sat_ov = pos_over || neg_over;
    if (pos_over) begin
      sat_result = `SAT_POS_MAX; // RULE_14
      sat_neg = 1'b0;
    end else if (neg_over) begin
      sat_result = `SAT_NEG_MAX; // RULE_14
      sat_neg = 1'b1;
    end else begin
      sat_result = sum_wide[31:0]; // RULE_15
      sat_neg = sum_wide[31];
    end
    sat_zero = (sat_result == 32'h00000000);
  end
endmodule

// File: verif/cpu_status_save_restore_tb.sv
// self-checking bench for the status word and save registers
// assumes the core's pipeline pulses are replaced by bench stimulus
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module cpu_status_save_restore_tb;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [25:0] next_pc = 26'h0;
  logic [15:0] cause_code = 16'h0;
  logic [7:0] ev = 8'h00;
  logic [4:0] sysreg_num = 5'h00;
  logic [31:0] sysreg_wdata = 32'h0;
  logic [3:0] alu_flags = 4'h0;
  logic [32:0] sat_sum = 33'h0;
  logic nmi_want = 1'b0;
  logic mask_want = 1'b0;
  logic nmi_req, mask_req, nmi_ack, mask_ack, sysreg_err, pc_load;
  logic [31:0] sysreg_rdata, sat_result_out;
  logic [25:0] pc_target, table_base_out;
  logic [7:0] psw_out;
  int fail_count = 0;
  int check_count = 0;
  always #5 sys_clk = ~sys_clk;
  // ------------------------------------------------------------
  // instances
  // ------------------------------------------------------------
  irq_source i_irq_source (.sys_clk(sys_clk), .reset_n(reset_n),
    .nmi_want(nmi_want), .mask_want(mask_want), .nmi_ack(nmi_ack),
    .mask_ack(mask_ack), .nmi_req(nmi_req), .mask_req(mask_req));
  cpu_status_save_restore i_cpu_status_save_restore (
    .sys_clk(sys_clk), .reset_n(reset_n), .cur_pc(26'h0),
    .next_pc(next_pc), .cause_code(cause_code), .nmi_req(nmi_req),
    .mask_req(mask_req), .exception_take(ev[0]), .trap_take(ev[1]),
    .table_call_exec(ev[2]), .interrupt_return_exec(ev[3]),
    .trap_return_exec(ev[4]), .sysreg_load(ev[5]),
    .sysreg_num(sysreg_num), .sysreg_wdata(sysreg_wdata),
    .alu_flag_we(ev[6]), .alu_flags(alu_flags), .sat_op(ev[7]),
    .sat_sum(sat_sum), .sysreg_rdata(sysreg_rdata),
    .sysreg_err(sysreg_err), .sat_result_out(sat_result_out),
    .nmi_ack(nmi_ack), .mask_ack(mask_ack), .pc_load(pc_load),
    .pc_target(pc_target), .psw_out(psw_out),
    .table_base_out(table_base_out));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task conclude;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task pulse(input logic [7:0] m);
    @(posedge sys_clk) ev <= m;
    @(posedge sys_clk) ev <= 8'h00;
    #1;
  endtask
  task ld(input logic [4:0] n, input logic [31:0] d);
    @(posedge sys_clk) begin
      sysreg_num <= n;
      sysreg_wdata <= d;
      ev <= 8'h20;
    end
    @(posedge sys_clk) ev <= 8'h00;
    #1;
  endtask
  task rd(input logic [4:0] n, input logic [31:0] exp);
    @(posedge sys_clk) sysreg_num <= n;
    @(posedge sys_clk);
    #1 `CHK(sysreg_rdata, exp)
  endtask
  // waits a bounded time; an expected ack that never comes ends the run
  task irq(input bit m, input bit exp);
    bit seen;
    seen = 1'b0;
    @(posedge sys_clk) if (m) mask_want <= 1'b1; else nmi_want <= 1'b1;
    for (int i = 0; i < 8 && !seen; i++) begin
      @(posedge sys_clk);
      seen = m ? (mask_ack === 1'b1) : (nmi_ack === 1'b1);
    end
    nmi_want <= 1'b0;
    mask_want <= 1'b0;
    `CHK(seen, exp)
    if (exp && !seen) conclude();
  endtask
  task satop(input logic [32:0] s, input logic [31:0] r,
             input logic [3:0] fl);
    @(posedge sys_clk) sat_sum <= s;
    pulse(8'h80);
    `CHK(sat_result_out, r)
    `CHK(psw_out[4:1], fl)
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task do_reset;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    #1 `CHK(pc_load, 1'b1)
    `CHK(pc_target, 26'h0)
    `CHK(psw_out, 8'h20)
  endtask
  task psw_gate;
    ld(5'h05, 32'hffffff20);
    rd(5'h05, 32'h00000020);
    irq(1'b1, 1'b0);
    // request already up when the load clearing the disable executes
    @(posedge sys_clk) mask_want <= 1'b1;
    @(posedge sys_clk) begin
      sysreg_num <= 5'h05;
      sysreg_wdata <= 32'h0;
      ev <= 8'h20;
    end
    @(posedge sys_clk) ev <= 8'h00;
    #1 `CHK(mask_ack, 1'b0)
    `CHK(psw_out[5], 1'b0)
    @(posedge sys_clk) mask_want <= 1'b0;
    #1 `CHK(mask_ack, 1'b1)
    // a load that sets the disable bit refuses a request already up
    @(posedge sys_clk) mask_want <= 1'b1;
    @(posedge sys_clk) begin
      sysreg_wdata <= 32'h20;
      ev <= 8'h20;
    end
    @(posedge sys_clk) begin
      ev <= 8'h00;
      mask_want <= 1'b0;
    end
    #1 `CHK(mask_ack, 1'b0)
    `CHK(psw_out[5], 1'b1)
  endtask
  task nmi_flow;
    @(posedge sys_clk) next_pc <= 26'h0123456;
    ld(5'h05, 32'h0000000a);
    irq(1'b0, 1'b1);
    #1 `CHK(psw_out[7], 1'b1)
    rd(5'h02, 32'h00123456);
    rd(5'h03, 32'h0000000a);
    irq(1'b1, 1'b0);
    ld(5'h02, 32'hfc123457);
    rd(5'h02, 32'h00123457);
    ld(5'h03, 32'hffffff0a);
    rd(5'h03, 32'h0000000a);
    pulse(8'h08);
    `CHK(pc_load, 1'b1)
    `CHK(pc_target, 26'h0123456)
    `CHK(psw_out, 8'h0a)
  endtask
  task cause_flow;
    @(posedge sys_clk) cause_code <= 16'h1234;
    pulse(8'h01);
    `CHK(psw_out[6], 1'b1)
    rd(5'h04, 32'h00001234);
    ld(5'h04, 32'hffffffff);
    `CHK(sysreg_err, 1'b1)
    rd(5'h04, 32'h00001234);
    ld(5'h05, 32'h00000040);
    irq(1'b1, 1'b1);
  endtask
  task sat_flow;
    ld(5'h05, 32'h0);
    satop(33'h000000005, 32'h00000005, 4'b0000);
    satop(33'h080000000, 32'h7fffffff, 4'b1010);
    satop(33'h17fffffff, 32'h80000000, 4'b1011);
    satop(33'h1fffffffe, 32'hfffffffe, 4'b1001);
    @(posedge sys_clk) alu_flags <= 4'b1001;
    pulse(8'h40);
    `CHK(psw_out[4:0], 5'b11001)
    ld(5'h05, 32'h0);
    `CHK(psw_out[4], 1'b0)
  endtask
  task table_flow;
    @(posedge sys_clk) next_pc <= 26'h2abcde4;
    ld(5'h05, 32'h00000013);
    pulse(8'h04);
    rd(5'h10, 32'h02abcde4);
    rd(5'h11, 32'h00000013);
    ld(5'h10, 32'hffffffff);
    rd(5'h10, 32'h03ffffff);
    ld(5'h11, 32'hffffffff);
    rd(5'h11, 32'h000000ff);
    ld(5'h14, 32'hffffffff);
    rd(5'h14, 32'h03fffffe);
    `CHK(table_base_out, 26'h3fffffe)
  endtask
  task trap_flow;
    ld(5'h12, 32'h1);
    `CHK(sysreg_err, 1'b1)
    rd(5'h12, 32'h0);
    @(posedge sys_clk) next_pc <= 26'h0000100;
    ld(5'h05, 32'h00000001);
    pulse(8'h02);
    rd(5'h12, 32'h00000100);
    rd(5'h13, 32'h00000001);
    ld(5'h12, 32'h00000204);
    `CHK(sysreg_err, 1'b0)
    rd(5'h12, 32'h00000204);
    pulse(8'h10);
    `CHK(pc_load, 1'b1)
    `CHK(pc_target, 26'h0000204)
    `CHK(psw_out, 8'h01)
    ld(5'h12, 32'h1);
    `CHK(sysreg_err, 1'b1)
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    do_reset();
    psw_gate();
    nmi_flow();
    cause_flow();
    sat_flow();
    table_flow();
    trap_flow();
    conclude();
  end
endmodule

// File: verif/irq_source.sv
// interrupt controller stand-in: turns a wish from the bench into a
// request level that stays up until the core acknowledges it or the wish drops
`timescale 1ns/1ns
module irq_source (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic nmi_want,
  input wire logic mask_want,
  input wire logic nmi_ack,
  input wire logic mask_ack,
  output logic nmi_req,
  output logic mask_req
);
  // ------------------------------------------------------------
  // request levels
  // ------------------------------------------------------------
  logic nmi_pend_ff;
  logic mask_pend_ff;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      nmi_pend_ff <= 1'b0;
      mask_pend_ff <= 1'b0;
    end else begin
      nmi_pend_ff <= nmi_want & ~nmi_ack;
      mask_pend_ff <= mask_want & ~mask_ack;
    end
  end
  // drop at once on ack so one request is never taken twice
  assign nmi_req = nmi_pend_ff & ~nmi_ack;
  assign mask_req = mask_pend_ff & ~mask_ack;
endmodule
